// ### i2c_slave_irq_ack_control_tb_top.sv
// Testbench for the target control and interrupt block.
`include "itc_consts.vh"
module i2c_slave_irq_ack_control_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, rd_q = 1'b0, wr_q = 1'b0, k1, k2;
   logic [3:0] addr_q = 4'h0;
   logic [31:0] wd_q = 32'h0, rv;
   logic [7:0] tx_q = 8'h00, bv;
   wire [31:0] rdata;
   wire [7:0] rxd;
   wire wait_w, scl, sda_m, sda_oe, irq;
   wire sda_pin = sda_m & ~sda_oe;
   int bad_count = 0, comparisons = 0;
   itc_target dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(addr_q), .avs_read_i(rd_q),
      .avs_write_i(wr_q), .avs_writedata_i(wd_q), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_w),
      .scl_i(scl), .sda_i(sda_pin), .sda_o(), .sda_oe_o(sda_oe), .tx_data_i(tx_q), .rx_data_o(rxd), .irq_o(irq));
   itc_i2c_master_model mdl_u (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_pin));
   initial forever #2.5 ref_clk_i = ~ref_clk_i;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_q <= a;
      wd_q <= d;
      wr_q <= w;
      rd_q <= ~w;
      do @(posedge ref_clk_i); while (wait_w !== 1'b0);
      rv = rdata;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      // Level outputs launched by this edge settle before any caller looks at them.
      @(negedge ref_clk_i);
   endtask
   task automatic wr_frame(input logic [7:0] d);
      mdl_u.start_frame();
      mdl_u.send_byte({`ITC_OWN_ADDR_RESET, 1'b0}, k1);
      if (k1 === 1'b0) mdl_u.send_byte(d, k2);
      mdl_u.stop_frame();
   endtask
   task automatic rd_frame();
      mdl_u.start_frame();
      mdl_u.send_byte({`ITC_OWN_ADDR_RESET, 1'b1}, k1);
      if (k1 === 1'b0) mdl_u.recv_byte(1'b1, bv);
      mdl_u.stop_frame();
   endtask
   task automatic t_regs();
      for (int i = 0; i < 16; i += 4) begin
         bus(1'b0, 4'(i), 32'h0);
         check(rv, (i == 12) ? {25'h0, `ITC_OWN_ADDR_RESET} : 32'h0);
      end
      bus(1'b0, 4'h2, 32'h0);
      check(rv, 32'h0);
      bus(1'b1, `ITC_OFF_CTRL, 32'hffff_ffbf);
      bus(1'b0, `ITC_OFF_CTRL, 32'h0);
      check(rv, {16'h0, `ITC_CTRL_WMASK});
   endtask
   task automatic t_nack();
      bus(1'b1, `ITC_OFF_MASK, 32'h7);
      wr_frame(8'h11);
      check({31'h0, k1}, 32'h1);
      bus(1'b0, `ITC_OFF_CTRL, 32'h0);
      check(rv, 32'h0700);
      check({31'h0, irq}, 32'h1);
      bus(1'b0, `ITC_OFF_STAT, 32'h0);
      check({31'h0, rv[2]}, 32'h1);
   endtask
   task automatic t_rx();
      wr_frame(8'ha5);
      check({30'h0, k1, k2}, 32'h0);
      check({24'h0, rxd}, 32'ha5);
      bus(1'b1, `ITC_OFF_MASK, 32'h0);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, `ITC_OFF_MASK, 32'h7);
      check({31'h0, irq}, 32'h1);
      bus(1'b0, `ITC_OFF_STAT, 32'h0);
      check(rv, 32'h5);
      check({31'h0, irq}, 32'h0);
   endtask
   task automatic t_tx();
      @(posedge ref_clk_i);
      tx_q <= 8'h5c;
      rd_frame();
      check({31'h0, k1}, 32'h0);
      check({24'h0, bv}, 32'h5c);
      bus(1'b0, `ITC_OFF_STAT, 32'h0);
      check(rv, 32'h6);
   endtask
   task automatic t_off();
      bus(1'b1, `ITC_OFF_CTRL, 32'h0);
      wr_frame(8'h3c);
      check({24'h0, rxd}, 32'h3c);
      rd_frame();
      check({31'h0, k1}, 32'h0);
      bus(1'b0, `ITC_OFF_STAT, 32'h0);
      check(rv, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask
   task automatic final_report();
      $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_nack();
      t_rx();
      t_tx();
      t_off();
      final_report();
   end
   // The frames need about 8 us; the limit leaves ample margin.
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
endmodule // i2c_slave_irq_ack_control_tb_top

// ### itc_consts.vh
// Constants for the I2C target control and interrupt block.
`ifndef ITC_CONSTS_VH
`define ITC_CONSTS_VH
`define ITC_ADDR_W 4
`define ITC_OFF_CTRL 4'h0
`define ITC_OFF_STAT 4'h4
`define ITC_OFF_MASK 4'h8
`define ITC_OFF_ADDR 4'hc
`define ITC_CTRL_RESET 16'h0000
`define ITC_BIT_TX_IRQ 10
`define ITC_BIT_RX_IRQ 9
`define ITC_BIT_STOP_IRQ 8
`define ITC_BIT_FORCE_NACK 7
`define ITC_BIT_RSVD 6
`define ITC_CTRL_WMASK 16'h0780
`define ITC_ST_RX 0
`define ITC_ST_TX 1
`define ITC_ST_STOP 2
`define ITC_ST_W 3
`define ITC_OWN_ADDR_RESET 7'h3a
`endif

// ### itc_i2c_master_model.sv
// Behavioural I2C bus controller driving the target's link pins.
module itc_i2c_master_model (
   // Link pins
   output logic scl_o,
   output logic sda_o,
   input wire sda_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // The clock stands high between frames; data moves 10 ns after the fall to give hold time.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic bit_io(input logic b, output logic r);
      #10 sda_o = b;
      #30 scl_o = 1'b1;
      #20 r = sda_i;
      #20 scl_o = 1'b0;
   endtask
   task automatic start_frame();
      sda_o = 1'b0;
      #40 scl_o = 1'b0;
   endtask
   task automatic stop_frame();
      #10 sda_o = 1'b0;
      #30 scl_o = 1'b1;
      #40 sda_o = 1'b1;
      #40;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, nack);
   endtask
   task automatic recv_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, r);
   endtask
endmodule // itc_i2c_master_model

// ### itc_sync.v
// Two-flop synchroniser for asynchronous pin inputs.
module itc_sync (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Data
   input wire d_i,
   output reg q_o
);
   reg meta_q;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b1;
         q_o <= 1'b1;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule // itc_sync

// ### itc_target.v
// I2C target engine with control register, interrupts and Avalon-MM slave.
//
// Register access over Avalon-MM and the address map were left to the implementer.
`include "itc_consts.vh"
module itc_target (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_i,
   // Avalon-MM slave
   input wire [`ITC_ADDR_W-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   // I2C pins
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe_o,
   // Transmit data and received data
   input wire [7:0] tx_data_i,
   output reg [7:0] rx_data_o,
   // Interrupt
   output wire irq_o
);
   localparam S_IDLE = 4'b0001;
   localparam S_BITS = 4'b0010;
   localparam S_ACK = 4'b0100;
   localparam S_TXACK = 4'b1000;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   wire scl_s;
   wire sda_s;
   reg scl_q;
   reg sda_q;
   itc_sync u_scl (.clk_i(ref_clk_i), .rst_i(rst_i), .d_i(scl_i), .q_o(scl_s));
   itc_sync u_sda (.clk_i(ref_clk_i), .rst_i(rst_i), .d_i(sda_i), .q_o(sda_s));
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_det = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_det = scl_s & scl_q & ~sda_q & sda_s;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [15:0] ctrl_q;
   reg [`ITC_ST_W-1:0] stat_q;
   reg [`ITC_ST_W-1:0] mask_q;
   reg [6:0] own_addr_q;
   reg rd_pend_q;
   wire wr_ctrl = avs_write_i & (avs_address_i == `ITC_OFF_CTRL);
   wire rd_stat = avs_read_i & ~rd_pend_q & (avs_address_i == `ITC_OFF_STAT);
   // One wait cycle on reads so read data come from a flop.
   assign avs_waitrequest_o = avs_read_i & ~rd_pend_q;

   // ----------------------------------------------------------------
   // Byte engine
   // ----------------------------------------------------------------
   reg [3:0] st_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg addr_ph_q;
   reg rnw_q;
   reg sel_q;
   reg drive_low_q;
   reg rx_ev;
   reg tx_ev;
   reg nack_used;
   wire ack_this = ~ctrl_q[`ITC_BIT_FORCE_NACK];

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= S_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         addr_ph_q <= 1'b0;
         rnw_q <= 1'b0;
         sel_q <= 1'b0;
         drive_low_q <= 1'b0;
         rx_data_o <= 8'h00;
      end else if (start_det) begin
         st_q <= S_BITS;
         bit_cnt_q <= 4'h0;
         addr_ph_q <= 1'b1;
         sel_q <= 1'b0;
         drive_low_q <= 1'b0;
      end else if (stop_det) begin
         st_q <= S_IDLE;
         drive_low_q <= 1'b0;
      end else begin
         case (st_q)
            S_IDLE: begin
               drive_low_q <= 1'b0;
            end
            S_BITS: begin
               if (scl_rise && !(sel_q && rnw_q)) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               if (scl_fall && sel_q && rnw_q) begin
                  drive_low_q <= ~shift_q[7];
                  shift_q <= {shift_q[6:0], 1'b1};
               end
               if (scl_fall && bit_cnt_q == 4'h8) begin
                  bit_cnt_q <= 4'h0;
                  if (sel_q && rnw_q) begin
                     drive_low_q <= 1'b0;
                     st_q <= S_TXACK;
                  end else if (addr_ph_q) begin
                     if (shift_q[7:1] == own_addr_q) begin
                        drive_low_q <= ack_this;
                        rnw_q <= shift_q[0];
                        sel_q <= ack_this;
                        st_q <= S_ACK;
                     end else begin
                        st_q <= S_IDLE;
                     end
                  end else begin
                     drive_low_q <= ack_this;
                     rx_data_o <= shift_q;
                     st_q <= S_ACK;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  addr_ph_q <= 1'b0;
                  if (!sel_q) begin
                     drive_low_q <= 1'b0;
                     st_q <= S_IDLE;
                  end else if (rnw_q) begin
                     shift_q <= {tx_data_i[6:0], 1'b1};
                     drive_low_q <= ~tx_data_i[7];
                     bit_cnt_q <= 4'h0;
                     st_q <= S_BITS;
                  end else begin
                     drive_low_q <= 1'b0;
                     st_q <= S_BITS;
                  end
               end
            end
            S_TXACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     st_q <= S_IDLE;
                  end else begin
                     st_q <= S_ACK;
                  end
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end

   always @* begin
      rx_ev = 1'b0;
      tx_ev = 1'b0;
      nack_used = 1'b0;
      if (!start_det && !stop_det && st_q == S_BITS && scl_fall && bit_cnt_q == 4'h8) begin
         tx_ev = sel_q & rnw_q;
         rx_ev = ~(sel_q & rnw_q) & ~addr_ph_q;
         // A byte meant for another target is not ours to refuse, so the forced refusal waits for our own.
         nack_used = ~(sel_q & rnw_q) & ctrl_q[`ITC_BIT_FORCE_NACK]
            & (~addr_ph_q | (shift_q[7:1] == own_addr_q));
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = drive_low_q;

   // ----------------------------------------------------------------
   // Register file and interrupts
   // ----------------------------------------------------------------
   wire [`ITC_ST_W-1:0] ev;
   assign ev[`ITC_ST_RX] = rx_ev & ctrl_q[`ITC_BIT_RX_IRQ];
   assign ev[`ITC_ST_TX] = tx_ev & ctrl_q[`ITC_BIT_TX_IRQ];
   assign ev[`ITC_ST_STOP] = stop_det & ctrl_q[`ITC_BIT_STOP_IRQ];

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `ITC_CTRL_RESET;
         stat_q <= {`ITC_ST_W{1'b0}};
         mask_q <= {`ITC_ST_W{1'b0}};
         own_addr_q <= `ITC_OWN_ADDR_RESET;
         rd_pend_q <= 1'b0;
         avs_readdata_o <= 32'h00000000;
      end else begin
         rd_pend_q <= avs_read_i & ~rd_pend_q;
         // Reserved bits are not stored, so bit 6 always reads zero.
         if (wr_ctrl) begin
            ctrl_q <= avs_writedata_i[15:0] & `ITC_CTRL_WMASK;
         end else if (nack_used) begin
            // Forced not-acknowledge covers one byte only.
            ctrl_q[`ITC_BIT_FORCE_NACK] <= 1'b0;
         end
         if (avs_write_i && avs_address_i == `ITC_OFF_MASK) begin
            mask_q <= avs_writedata_i[`ITC_ST_W-1:0];
         end
         if (avs_write_i && avs_address_i == `ITC_OFF_ADDR) begin
            own_addr_q <= avs_writedata_i[6:0];
         end
         // A new event in the read cycle survives the clear.
         stat_q <= (rd_stat ? {`ITC_ST_W{1'b0}} : stat_q) | ev;
         if (avs_read_i && !rd_pend_q) begin
            case (avs_address_i)
               `ITC_OFF_CTRL: avs_readdata_o <= {16'h0000, ctrl_q};
               `ITC_OFF_STAT: avs_readdata_o <= {29'h0, stat_q};
               `ITC_OFF_MASK: avs_readdata_o <= {29'h0, mask_q};
               `ITC_OFF_ADDR: avs_readdata_o <= {25'h0, own_addr_q};
               default: avs_readdata_o <= 32'h00000000;
            endcase
         end
      end
   end

   assign irq_o = |(stat_q & mask_q);
endmodule // itc_target

// ### itc_target_sva.sv
// Checker for the target block's bus, pin and interrupt behaviour.
`include "itc_consts.vh"
module itc_target_sva (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_i,
   // Avalon-MM slave
   input wire [`ITC_ADDR_W-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   // Pins and interrupt
   input wire scl_i,
   input wire sda_o,
   input wire sda_oe_o,
   input wire irq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bit 7 self-clears inside the block, so the shadow is never compared there.
   logic [15:0] ctrl_q;
   logic [2:0] mask_q;
   wire rd_done = avs_read_i && !avs_waitrequest_o;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `ITC_CTRL_RESET;
         mask_q <= 3'h0;
      end else if (avs_write_i && avs_address_i == `ITC_OFF_CTRL) begin
         ctrl_q <= avs_writedata_i[15:0] & `ITC_CTRL_WMASK;
      end else if (avs_write_i && avs_address_i == `ITC_OFF_MASK) begin
         mask_q <= avs_writedata_i[2:0];
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_read_waits_once: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("read answer timing wrong");
   a_write_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o)
      else $error("write was held off");
   a_ctrl_read_value: assert property (rd_done && avs_address_i == `ITC_OFF_CTRL |->
      avs_readdata_o[31:8] == {16'h0000, ctrl_q[15:8]} && avs_readdata_o[6:0] == 7'h00)
      else $error("control read value wrong");
   a_unmapped_reads_zero: assert property (rd_done && avs_address_i[1:0] != 2'b00 |->
      avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_data_stands: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i && avs_waitrequest_o))
      else $error("read data changed outside a read");
   a_sda_open_drain: assert property (!sda_o)
      else $error("data pin driven high");
   // The pin driver may only move while the link clock is low, else a false start or stop appears.
   a_drive_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data pin drive changed while clock high");
   a_irq_needs_mask: assert property (mask_q == 3'h0 |-> !irq_o)
      else $error("interrupt with all sources masked");
   a_irq_needs_enable: assert property ($rose(irq_o) && !$past(avs_write_i) |->
      ctrl_q[10:8] != 3'h0)
      else $error("interrupt from a disabled source");
   cover property (rd_done && avs_address_i == `ITC_OFF_STAT);
   cover property ($rose(irq_o));
   cover property ($rose(sda_oe_o));
endmodule // itc_target_sva
bind itc_target itc_target_sva chk_u (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
   .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .scl_i, .sda_o, .sda_oe_o, .irq_o);
